// >>> rcpu_core.sv
// Function
// - Register-to-register operation completes in one cycle unless it writes PC.
// - Sixteen registers; R0-R3 are PC, SP, SR, CG.
// - Register operations; seven source, four destination modes.
// - Three formats; every operation word or byte, except push and call (word only).
// - Call pushes program counter, then loads operand.
// - Conditional jumps; jump_if_not_equal branches when Z clear.
// - Autoincrement reads through pointer, then adds two (one for a byte operand).
// - Indirect, autoincrement, immediate only for source operand.
`timescale 1ns/10ps
`include "rcpu_defs.svh"
module rcpu_core
	import rcpu_pkg::*;
#(
	parameter logic [15:0] RESET_PC = `RCPU_RST_PC
) (
	input  wire logic        core_clk,
	input  wire logic        reset,
	input  wire logic        ce,
	output logic [15:0]      mem_addr,
	output logic             mem_rd,
	output logic             mem_wr,
	output logic             mem_byte,
	output logic [15:0]      mem_wdata,
	input  wire logic [15:0] mem_rdata,
	output logic [15:0]      cur_pc,
	output logic [15:0]      cur_sr
);
	rcpu_rf_if rf ();

	rcpu_regfile #(
		.RESET_PC (RESET_PC)
	) u_rf (
		.core_clk (core_clk),
		.reset    (reset),
		.ce       (ce),
		.rf       (rf.rf)
	);

	rcpu_state_t state;
	rcpu_state_t next_state;
	logic [15:0] ir;
	logic [15:0] next_ir;
	logic [15:0] opnd;
	logic [15:0] next_opnd;
	logic [15:0] eaddr;
	logic [15:0] next_eaddr;
	logic [15:0] next_addr;
	logic [15:0] next_wdata;
	logic        next_rd;
	logic        next_wr;
	logic        next_byte;
	logic        do_fetch;
	rcpu_alu_t   alu;

	// Operation unit. Codes 0-3 are the single-operand forms, 4-f the
	// dual-operand ones; code a has no datapath and behaves as a no-op.
	function automatic rcpu_alu_t alu_f(input logic [3:0] op,
		input logic bw, input logic [15:0] s_in, input logic [15:0] d_in,
		input logic [15:0] sr);
		rcpu_alu_t   o;
		logic [15:0] s;
		logic [15:0] d;
		logic [15:0] a;
		logic [15:0] r;
		logic [16:0] sum;
		logic        cin;
		logic        c;
		logic        arith;
		logic        msb_r;
		s = bw ? {8'h00, s_in[7:0]} : s_in;
		d = bw ? {8'h00, d_in[7:0]} : d_in;
		arith = op >= 4'h5 && op <= 4'h9;
		a = s;
		if (op >= 4'h7 && op <= 4'h9)
			a = bw ? {8'h00, ~s[7:0]} : ~s;
		cin = (op == 4'h6 || op == 4'h7) ? sr[`RCPU_SR_C] : op >= 4'h8;
		sum = {1'b0, d} + {1'b0, a} + {16'h0000, cin};
		c = bw ? sum[8] : sum[16];
		r = sum[15:0];
		o.wr = 1'b1;
		o.upd = 1'b1;
		case (op)
			4'h0: begin
				r = bw ? {8'h00, sr[`RCPU_SR_C], s[7:1]}
					: {sr[`RCPU_SR_C], s[15:1]};
				c = s[0];
			end
			4'h1: begin
				r = {s_in[7:0], s_in[15:8]};
				o.upd = 1'b0;
			end
			4'h2: begin
				r = bw ? {8'h00, s[7], s[7:1]} : {s[15], s[15:1]};
				c = s[0];
			end
			4'h3: begin
				r = {{8{s[7]}}, s[7:0]};
				c = r != 16'h0000;
			end
			4'h4: begin
				r = s;
				o.upd = 1'b0;
			end
			4'h5, 4'h6, 4'h7, 4'h8: ;
			4'h9: o.wr = 1'b0;
			4'hb: begin
				r = d & s;
				c = r != 16'h0000;
				o.wr = 1'b0;
			end
			4'hc: begin
				r = d & ~s;
				o.upd = 1'b0;
			end
			4'hd: begin
				r = d | s;
				o.upd = 1'b0;
			end
			4'he: begin
				r = d ^ s;
				c = r != 16'h0000;
			end
			4'hf: begin
				r = d & s;
				c = r != 16'h0000;
			end
			default: begin
				r = d;
				o.wr = 1'b0;
				o.upd = 1'b0;
			end
		endcase
		if (bw)
			r[15:8] = 8'h00;
		msb_r = bw ? r[7] : r[15];
		o.res = r;
		o.sr = sr;
		if (o.upd) begin
			o.sr[`RCPU_SR_C] = c;
			o.sr[`RCPU_SR_Z] = r == 16'h0000;
			o.sr[`RCPU_SR_N] = msb_r;
			o.sr[`RCPU_SR_V] = arith && (bw ? (a[7] == d[7] && msb_r != d[7])
				: (a[15] == d[15] && msb_r != d[15]));
		end
		return o;
	endfunction

	// Instruction fields; the word comes straight off the bus while
	// decoding so that register operations need no extra cycle.
	wire logic [15:0] iw = (state == st_dec) ? mem_rdata : ir;
	wire logic        is_jmp = iw[15:13] == `RCPU_JMP_PREFIX;
	wire logic        is_one = iw[15:10] == `RCPU_ONE_PREFIX;
	wire logic        is_two = iw[15:14] != 2'h0;
	wire logic [2:0]  one_op = iw[9:7];
	wire logic        is_stk = is_one && one_op[2:1] == 2'h2;
	wire logic        is_call = is_stk && one_op[0];
	wire logic [3:0]  sreg = is_one ? iw[3:0] : iw[11:8];
	wire logic [3:0]  dreg = iw[3:0];
	wire logic        ad = iw[7];
	wire logic        bw = iw[6];
	wire logic [1:0]  as_m = iw[5:4];
	wire logic [2:0]  jcond = iw[12:10];

	// Constant generator: R3 yields 0, 1, 2 or all ones, R2 in the two
	// indirect modes yields 4 or 8, so no memory cycle is spent.
	wire logic        cg_hit = sreg == `RCPU_REG_CG ||
		(sreg == `RCPU_REG_SR && as_m[1]);
	wire logic [15:0] cg_val = (sreg == `RCPU_REG_SR) ?
		(as_m[0] ? 16'h0008 : 16'h0004) :
		(as_m == 2'h3 ? 16'hffff : {14'h0000, as_m});
	wire logic [15:0] src_val = cg_hit ? cg_val : rf.da;
	wire logic        src_regm = as_m == 2'h0 || cg_hit;
	wire logic        simple = (is_two && src_regm && !ad) ||
		(is_one && as_m == 2'h0 && !one_op[2]);
	wire logic [15:0] step = bw ? `RCPU_BYTE_STEP : `RCPU_WORD_STEP;
	wire logic [15:0] rdat = bw ? {8'h00, mem_rdata[7:0]} : mem_rdata;
	wire logic [15:0] ext_pc = rf.pc - `RCPU_WORD_STEP;
	wire logic [15:0] sp_dec = rf.sp - `RCPU_WORD_STEP;

	// Indexed base: PC gives symbolic, SR gives absolute (base zero).
	wire logic [15:0] sx_base = (sreg == `RCPU_REG_PC) ? ext_pc :
		(sreg == `RCPU_REG_SR) ? 16'h0000 : rf.da;
	wire logic [15:0] dx_base = (dreg == `RCPU_REG_PC) ? ext_pc :
		(dreg == `RCPU_REG_SR) ? 16'h0000 : rf.db;

	// Operand selection and result routing.
	wire logic [3:0]  alu_op = is_one ? {1'b0, one_op} : iw[15:12];
	wire logic [15:0] alu_s = (state == st_sr) ? rdat :
		(state == st_dr) ? opnd : src_val;
	wire logic [15:0] alu_d = (state == st_dr) ? rdat : rf.db;
	wire logic [3:0]  wreg = is_one ? sreg : dreg;
	wire logic        reg_wr = alu.wr && wreg != `RCPU_REG_CG;
	wire logic        to_pc = reg_wr && wreg == `RCPU_REG_PC;
	assign alu = alu_f(alu_op, bw, alu_s, alu_d, rf.sr);

	// Jump conditions indexed by the condition field; entry 0 is
	// jump_if_not_equal.
	wire logic        f_z = rf.sr[`RCPU_SR_Z];
	wire logic        f_c = rf.sr[`RCPU_SR_C];
	wire logic        f_nv = rf.sr[`RCPU_SR_N] ^ rf.sr[`RCPU_SR_V];
	wire logic [7:0]  jtab = {1'b1, f_nv, !f_nv, rf.sr[`RCPU_SR_N],
		f_c, !f_c, f_z, !f_z};
	wire logic        jmp_take = jtab[jcond];
	wire logic [15:0] jmp_tgt = rf.pc + {{5{iw[9]}}, iw[9:0], 1'b0};

	assign rf.ra = sreg;
	assign rf.rb = dreg;
	assign cur_pc = rf.pc;
	assign cur_sr = rf.sr;

	// Sequencer. Memory operands walk through extension, source and
	// destination states; register work stays in the decode state unless it writes PC.
	always_comb begin
		next_state = state;
		next_ir = ir;
		next_opnd = opnd;
		next_eaddr = eaddr;
		next_addr = mem_addr;
		next_wdata = mem_wdata;
		next_rd = 1'b0;
		next_wr = 1'b0;
		next_byte = 1'b0;
		do_fetch = 1'b0;
		rf.w0_we = 1'b0;
		rf.w0_a = wreg;
		rf.w0_d = alu.res;
		rf.w1_we = 1'b0;
		rf.w1_a = sreg;
		rf.w1_d = rf.da + step;
		rf.pc_we = 1'b0;
		rf.pc_d = rf.pc + `RCPU_WORD_STEP;
		rf.sr_we = 1'b0;
		rf.sr_d = alu.sr;
		case (state)
			st_fetch: do_fetch = 1'b1;
			st_dec: begin
				if (is_jmp) begin
					next_addr = jmp_take ? jmp_tgt : rf.pc;
					next_rd = 1'b1;
					rf.pc_we = 1'b1;
					rf.pc_d = next_addr + `RCPU_WORD_STEP;
				end else if (simple) begin
					rf.w0_we = reg_wr;
					rf.sr_we = alu.upd;
					do_fetch = !to_pc;
					next_state = to_pc ? st_fetch : st_dec;
				end else if (is_stk && as_m == 2'h0) begin
					next_ir = iw;
					next_state = st_push;
				end else if (is_two && !src_regm && as_m == 2'h1) begin
					next_ir = iw;
					next_addr = rf.pc;
					next_rd = 1'b1;
					rf.pc_we = 1'b1;
					next_state = st_sx;
				end else if (is_two && !src_regm) begin
					next_ir = iw;
					next_rd = 1'b1;
					next_byte = bw;
					next_addr = (sreg == `RCPU_REG_PC) ? rf.pc : rf.da;
					rf.pc_we = sreg == `RCPU_REG_PC && as_m[0];
					rf.w1_we = sreg != `RCPU_REG_PC && as_m[0];
					next_state = st_sr;
				end else if (is_two) begin
					next_ir = iw;
					next_opnd = src_val;
					next_addr = rf.pc;
					next_rd = 1'b1;
					rf.pc_we = 1'b1;
					next_state = st_dx;
				end else begin
					do_fetch = 1'b1;
				end
			end
			st_sx: begin
				next_addr = sx_base + mem_rdata;
				next_rd = 1'b1;
				next_byte = bw;
				next_state = st_sr;
			end
			st_sr: begin
				if (!ad) begin
					rf.w0_we = reg_wr;
					rf.sr_we = alu.upd;
					do_fetch = !to_pc;
					next_state = to_pc ? st_fetch : st_dec;
				end else begin
					next_opnd = rdat;
					next_addr = rf.pc;
					next_rd = 1'b1;
					rf.pc_we = 1'b1;
					next_state = st_dx;
				end
			end
			st_dx: begin
				next_eaddr = dx_base + mem_rdata;
				next_addr = next_eaddr;
				next_rd = 1'b1;
				next_byte = bw;
				next_state = st_dr;
			end
			st_dr: begin
				rf.sr_we = alu.upd;
				next_wr = alu.wr;
				next_addr = eaddr;
				next_wdata = alu.res;
				next_byte = bw;
				next_state = st_fetch;
			end
			st_push: begin
				next_addr = sp_dec;
				next_wr = 1'b1;
				next_wdata = is_call ? rf.pc : src_val;
				rf.w1_we = 1'b1;
				rf.w1_a = `RCPU_REG_SP;
				rf.w1_d = sp_dec;
				rf.pc_we = is_call;
				rf.pc_d = src_val;
				next_state = st_fetch;
			end
			default: next_state = st_fetch;
		endcase
		if (do_fetch) begin
			next_addr = rf.pc;
			next_rd = 1'b1;
			rf.pc_we = 1'b1;
			next_state = st_dec;
		end
	end

	// Sequencer state; frozen while the clock enable is low.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state <= st_fetch;
			ir <= 16'h0000;
			opnd <= 16'h0000;
			eaddr <= 16'h0000;
		end else if (ce) begin
			state <= next_state;
			ir <= next_ir;
			opnd <= next_opnd;
			eaddr <= next_eaddr;
		end
	end

	// Bus outputs are registered so the memory sees clean strobes.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			mem_addr <= 16'h0000;
			mem_rd <= 1'b0;
			mem_wr <= 1'b0;
			mem_byte <= 1'b0;
			mem_wdata <= 16'h0000;
		end else if (ce) begin
			mem_addr <= next_addr;
			mem_rd <= next_rd;
			mem_wr <= next_wr;
			mem_byte <= next_byte;
			mem_wdata <= next_wdata;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	wire logic a_autoinc = state == st_dec && is_two && !cg_hit &&
		as_m == 2'h3 && sreg != `RCPU_REG_PC && ce;

	a_regreg_single: assert property (
		state == st_dec && simple && !is_jmp && !to_pc && ce |=>
		state == st_dec && mem_rd && mem_addr == $past(cur_pc))
		else $error("register operation took more than one cycle");
	a_src_indexed: assert property (
		state == st_dec && is_two && !src_regm && as_m == 2'h1 && ce
		|=> state == st_sx ##1 (state == st_sx || state == st_sr))
		else $error("indexed source skipped extension fetch");
	a_byte_zero_ext: assert property (
		rf.w0_we && bw && (state == st_dec || state == st_sr) |->
		rf.w0_d[15:8] == 8'h00)
		else $error("byte result has a nonzero high byte");
	a_call_push: assert property (
		state == st_push && is_call && ce |=> mem_wr &&
		mem_wdata == $past(cur_pc) && mem_addr == $past(sp_dec) &&
		cur_pc == $past(src_val))
		else $error("call did not push and load the program counter");
	a_not_equal_jump: assert property (
		state == st_dec && is_jmp && jcond == 3'h0 && ce |=>
		mem_addr == ($past(f_z) ? $past(cur_pc) : $past(jmp_tgt)))
		else $error("jump_if_not_equal took the wrong path");
	a_autoinc_word: assert property (
		a_autoinc && !bw |=> state == st_sr &&
		mem_addr == $past(src_val) &&
		rf.da == $past(src_val) + `RCPU_WORD_STEP)
		else $error("word autoincrement did not add two");
	a_autoinc_byte: assert property (
		a_autoinc && bw |=> state == st_sr &&
		rf.da == $past(src_val) + `RCPU_BYTE_STEP)
		else $error("byte autoincrement did not add one");
	a_dest_modes: assert property (
		$rose(mem_wr) |-> $past(state) == st_dr ||
		$past(state) == st_push)
		else $error("memory write outside destination or push");

	c_regreg: cover property (state == st_dec && simple && ce ##1
		state == st_dec);
	c_call: cover property (state == st_push && is_call && ce);
	c_not_equal_taken: cover property (state == st_dec && is_jmp &&
		jcond == 3'h0 && !f_z && ce);
	c_mem_dest: cover property (state == st_dr && alu.wr && ce);
endmodule // rcpu_core

// >>> rcpu_defs.svh
`ifndef RCPU_DEFS_SVH
`define RCPU_DEFS_SVH

// Dedicated register indices.
`define RCPU_REG_PC 4'h0
`define RCPU_REG_SP 4'h1
`define RCPU_REG_SR 4'h2
`define RCPU_REG_CG 4'h3

// Status register bit positions.
`define RCPU_SR_C 0
`define RCPU_SR_Z 1
`define RCPU_SR_N 2
`define RCPU_SR_V 8

// Reset values.
`define RCPU_RST_PC 16'h0000
`define RCPU_RST_REG 16'h0000

// Pointer steps for word and byte operands.
`define RCPU_WORD_STEP 16'h0002
`define RCPU_BYTE_STEP 16'h0001

// Instruction format prefixes.
`define RCPU_JMP_PREFIX 3'h1
`define RCPU_ONE_PREFIX 6'h04

`endif

// >>> rcpu_pkg.sv
package rcpu_pkg;

	// Sequencer states, one-hot.
	typedef enum logic [6:0] {
		st_fetch = 7'h01,
		st_dec   = 7'h02,
		st_sx    = 7'h04,
		st_sr    = 7'h08,
		st_dx    = 7'h10,
		st_dr    = 7'h20,
		st_push  = 7'h40
	} rcpu_state_t;

	// Result of one operation: value, new status, write and flag enables.
	typedef struct packed {
		logic [15:0] res;
		logic [15:0] sr;
		logic        wr;
		logic        upd;
	} rcpu_alu_t;

endpackage

// >>> rcpu_rf_if.sv
`timescale 1ns/10ps
// Register file access between sequencer and register array.
interface rcpu_rf_if;
	logic [3:0]  ra;
	logic [3:0]  rb;
	logic [15:0] da;
	logic [15:0] db;
	logic [15:0] pc;
	logic [15:0] sp;
	logic [15:0] sr;
	logic        w0_we;
	logic [3:0]  w0_a;
	logic [15:0] w0_d;
	logic        w1_we;
	logic [3:0]  w1_a;
	logic [15:0] w1_d;
	logic        pc_we;
	logic [15:0] pc_d;
	logic        sr_we;
	logic [15:0] sr_d;

	modport core (output ra, rb, w0_we, w0_a, w0_d, w1_we, w1_a, w1_d,
		pc_we, pc_d, sr_we, sr_d, input da, db, pc, sp, sr);
	modport rf (input ra, rb, w0_we, w0_a, w0_d, w1_we, w1_a, w1_d,
		pc_we, pc_d, sr_we, sr_d, output da, db, pc, sp, sr);
endinterface // rcpu_rf_if

// >>> rcpu_regfile.sv
`timescale 1ns/10ps
`include "rcpu_defs.svh"
module rcpu_regfile
	import rcpu_pkg::*;
#(
	parameter logic [15:0] RESET_PC = `RCPU_RST_PC
) (
	input  wire logic core_clk,
	input  wire logic reset,
	input  wire logic ce,
	rcpu_rf_if.rf     rf
);
	logic [15:0] r [16];

	// Each entry picks its write source; the result port wins over the
	// pointer port, which wins over the implicit program counter and status
	// updates. The constant generator entry is never written.
	for (genvar i = 0; i < 16; i++) begin : g_reg
		wire logic        hit0 = rf.w0_we && rf.w0_a == 4'(i);
		wire logic        hit1 = rf.w1_we && rf.w1_a == 4'(i);
		wire logic        hitp = (i == 0) && rf.pc_we;
		wire logic        hits = (i == 2) && rf.sr_we;
		wire logic        we   = (hit0 || hit1 || hitp || hits) && (i != 3);
		wire logic [15:0] wv   = hit0 ? rf.w0_d : hit1 ? rf.w1_d :
			hitp ? rf.pc_d : rf.sr_d;
		always_ff @(posedge core_clk or posedge reset) begin
			if (reset) begin
				r[i] <= (i == 0) ? RESET_PC : `RCPU_RST_REG;
			end else if (ce && we) begin
				r[i] <= (i == 0) ? {wv[15:1], 1'b0} : wv;
			end
		end
	end

	// Read ports are plain selects on the flop array.
	assign rf.da = r[rf.ra];
	assign rf.db = r[rf.rb];
	assign rf.pc = r[`RCPU_REG_PC];
	assign rf.sp = r[`RCPU_REG_SP];
	assign rf.sr = r[`RCPU_REG_SR];

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	a_cg_stays_zero: assert property (
		r[`RCPU_REG_CG] == `RCPU_RST_REG)
		else $error("constant generator entry was written");
	a_pc_word_aligned: assert property (
		$changed(rf.pc) |-> rf.pc[0] == 1'b0)
		else $error("program counter became odd");
endmodule // rcpu_regfile

// >>> rcpu_mem_model.sv
`timescale 1ns/10ps
// Zero-wait program and data memory seen by the core's bus.
module rcpu_mem_model (
	input  wire logic        core_clk,
	input  wire logic [15:0] mem_addr,
	input  wire logic        mem_rd,
	input  wire logic        mem_wr,
	input  wire logic        mem_byte,
	input  wire logic [15:0] mem_wdata,
	output logic [15:0]      mem_rdata
);
	logic [15:0] mem [0:511];
	logic [15:0] last;
	logic [15:0] word;
	logic [7:0]  lane;

	initial last = 16'h0000;

	// Addressed word, and the byte lane that address bit 0 selects.
	assign word = mem[mem_addr[9:1]];
	assign lane = mem_addr[0] ? word[15:8] : word[7:0];

	// Outside a read the bus shows the inverse of the last value, so a
	// core that samples late cannot pass on a stale copy by luck.
	assign mem_rdata = !mem_rd ? ~last : (mem_byte ? {8'h00, lane} : word);

	// Writes land at the edge that ends the write cycle.
	always @(posedge core_clk) begin
		if (mem_rd)
			last <= mem_rdata;
		if (mem_wr && mem_byte && mem_addr[0])
			mem[mem_addr[9:1]][15:8] <= mem_wdata[7:0];
		else if (mem_wr && mem_byte)
			mem[mem_addr[9:1]][7:0] <= mem_wdata[7:0];
		else if (mem_wr)
			mem[mem_addr[9:1]] <= mem_wdata;
	end
endmodule // rcpu_mem_model

// >>> risc_cpu_operand_addressing_bench.sv
`timescale 1ns/10ps
// The core runs small hand-assembled programs out of the memory model.
module risc_cpu_operand_addressing_bench;
	localparam logic [15:0] START = 16'h0000;

	logic        core_clk;
	logic        reset;
	logic        ce;
	logic [15:0] mem_addr;
	logic        mem_rd;
	logic        mem_wr;
	logic        mem_byte;
	logic [15:0] mem_wdata;
	logic [15:0] mem_rdata;
	logic [15:0] cur_pc;
	logic [15:0] cur_sr;
	int          failures;
	int          n_checks;

	rcpu_core #(.RESET_PC(START)) dut_u (
		.core_clk (core_clk),
		.reset    (reset),
		.ce       (ce),
		.mem_addr (mem_addr),
		.mem_rd   (mem_rd),
		.mem_wr   (mem_wr),
		.mem_byte (mem_byte),
		.mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata),
		.cur_pc   (cur_pc),
		.cur_sr   (cur_sr)
	);

	rcpu_mem_model mem_u (
		.core_clk (core_clk),
		.mem_addr (mem_addr),
		.mem_rd   (mem_rd),
		.mem_wr   (mem_wr),
		.mem_byte (mem_byte),
		.mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata)
	);

	// Clock at 50 MHz.
	always #10 core_clk = ~core_clk;

	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("checks=%0d mismatches=%0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Inputs always move one nanosecond after the rising edge.
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	// Waits for a read (wr=0) or write (wr=1) cycle at one address.
	task automatic wait_bus(input logic wr, input logic [15:0] a,
		input int bound);
		for (int i = 0; i < bound; i++) begin
			if ((wr ? mem_wr : mem_rd) === 1'b1 && mem_addr === a)
				return;
			tick(1);
		end
		failures++;
		$display("MISMATCH t=%0t got=%h exp=%h", $time, mem_addr, a);
		report_and_stop();
	endtask

	// Loads a program, resets the core and checks the first fetch.
	task automatic boot(input logic [15:0] w[$], input int hold);
		reset = 1'b1;
		for (int i = 0; i < 512; i++)
			mem_u.mem[i] = 16'h0000;
		foreach (w[i])
			mem_u.mem[START[9:1] + i] = w[i];
		tick(hold);
		chk16(cur_pc, START);
		chk16(cur_sr, 16'h0000);
		chk16({15'h0000, mem_rd}, 16'h0000);
		reset = 1'b0;
		tick(1);
		chk16(mem_addr, START);
		chk16({15'h0000, mem_rd}, 16'h0001);
	endtask

	// Register-to-register add takes one cycle; a frozen clock enable
	// must hold the bus where it stands.
	task automatic test_reg_reg();
		boot('{16'h4034, 16'h1234, 16'h4035, 16'h0111, 16'h5405,
			16'h4582, 16'h0200, 16'h3fff}, 16);
		wait_bus(1'b0, 16'h0008, 20);
		tick(1);
		chk16(mem_addr, 16'h000a);
		chk16({15'h0000, mem_rd}, 16'h0001);
		ce = 1'b0;
		tick(3);
		chk16(mem_addr, 16'h000a);
		ce = 1'b1;
		wait_bus(1'b0, 16'h000e, 20);
		chk16(mem_u.mem[9'h100], 16'h1345);
		$display("test reg_reg done");
	endtask

	// Word then byte autoincrement through one pointer.
	task automatic test_autoinc();
		boot('{16'h4036, 16'h0300, 16'h4637, 16'h4678, 16'h4682,
			16'h0202, 16'h4782, 16'h0204, 16'h4882, 16'h0206,
			16'h3fff}, 2);
		mem_u.mem[9'h180] = 16'hbeef;
		mem_u.mem[9'h181] = 16'h77a5;
		wait_bus(1'b0, 16'h0014, 60);
		chk16(mem_u.mem[9'h101], 16'h0303);
		chk16(mem_u.mem[9'h102], 16'hbeef);
		chk16(mem_u.mem[9'h103], 16'h00a5);
		$display("test autoinc done");
	endtask

	// Call pushes the return address below the stack top, then jumps.
	task automatic test_call();
		boot('{16'h4031, 16'h0400, 16'h4038, 16'h0040, 16'h1288}, 2);
		mem_u.mem[9'h020] = 16'h3fff;
		wait_bus(1'b1, 16'h03fe, 20);
		chk16(mem_wdata, 16'h000a);
		chk16({15'h0000, mem_byte}, 16'h0000);
		wait_bus(1'b0, 16'h0040, 3);
		chk16(mem_u.mem[9'h1ff], 16'h000a);
		$display("test call done");
	endtask

	// Jump-if-not-equal falls through when equal, branches otherwise.
	task automatic test_jump();
		boot('{16'h4034, 16'h0005, 16'h9034, 16'h0005, 16'h2003,
			16'h40b2, 16'h1111, 16'h0208, 16'h9034, 16'h0006,
			16'h2003, 16'h40b2, 16'h2222, 16'h020a, 16'h3fff}, 2);
		mem_u.mem[9'h105] = 16'hdead;
		wait_bus(1'b0, 16'h0014, 60);
		tick(1);
		chk16(mem_addr, 16'h001c);
		chk16(mem_u.mem[9'h104], 16'h1111);
		chk16(mem_u.mem[9'h105], 16'hdead);
		tick(3);
		chk16(mem_addr, 16'h001c);
		$display("test jump done");
	endtask

	// Indexed, indirect and symbolic sources, the constant generator,
	// a register-based indexed destination and a byte store to an odd
	// address. The add of one to 7fff must leave N and V set.
	task automatic test_modes();
		boot('{16'h4039, 16'h0300, 16'h491a, 16'h0004, 16'h492b,
			16'h4a89, 16'h0002, 16'h401c, 16'h02f8, 16'h531c,
			16'h4ac2, 16'h0207, 16'h4b82, 16'h0204, 16'h4c82,
			16'h0208, 16'h3fff}, 2);
		mem_u.mem[9'h180] = 16'h5a5a;
		mem_u.mem[9'h182] = 16'h1234;
		mem_u.mem[9'h184] = 16'h7fff;
		mem_u.mem[9'h103] = 16'habcd;
		wait_bus(1'b0, 16'h0020, 80);
		chk16(mem_u.mem[9'h181], 16'h1234);
		chk16(mem_u.mem[9'h102], 16'h5a5a);
		chk16(mem_u.mem[9'h103], 16'h34cd);
		chk16(mem_u.mem[9'h104], 16'h8000);
		chk16(cur_sr, 16'h0104);
		$display("test modes done");
	endtask

	initial begin
		core_clk = 1'b0;
		reset = 1'b1;
		ce = 1'b1;
		failures = 0;
		n_checks = 0;
		#1;
		test_reg_reg();
		test_autoinc();
		test_call();
		test_jump();
		test_modes();
		report_and_stop();
	end
endmodule // risc_cpu_operand_addressing_bench
